/* File: div_pkg.sv */
// constants shared by the interrupt vectoring block
// Contract
// - vector slots sit four words apart; reset 0, nmi 4, software 8-60, 120-127 reserved.
// - reset vectors to slot 0 at priority 1; nmi priority 2; channel 5 lowest 16.
// - external pins 0-2 use slots 64/68/72, priorities 3-5, bits 0-2.
// - external pin 3 uses slot 96, priority 11, bit 8.
// - timer 0 uses slot 76, priority 6, bit 3.
// - serial 0 receive slot 80 priority 7 bit 4; transmit slot 84 priority 8 bit 5.
// - slot 88, bit 6 reserved unless dma control selects dma channel 0.
// - slot 92, bit 7 carries timer 1 unless dma control selects dma channel 1.
// - host port interrupt uses slot 100, priority 12, bit 9.
// - slot 104, bit 10 carries serial 1 receive unless dma control selects channel 2.
// - slot 108, bit 11 carries serial 1 transmit unless dma control selects channel 3.
// - dma channel 4 slot 112 bit 12; channel 5 slot 116 bit 13.
// - bits 15-14 of flag and mask registers are reserved, no source.
// - flag and mask registers share one bit layout, one source per bit.
// - the dma source select register is directly bus mapped.
package div_pkg;
  // ----------------------------------------
  // source layout, shared by flags and masks
  // ----------------------------------------
  localparam int         NUM_SRC   = 14;
  localparam int         NUM_EVT   = 4;
  localparam int         BIT_EXT0  = 0;
  localparam int         BIT_TMR0  = 3;
  localparam int         BIT_SR0RX = 4;
  localparam int         BIT_SR0TX = 5;
  localparam int         BIT_DMA0  = 6;
  localparam int         BIT_TMR1  = 7;
  localparam int         BIT_EXT3  = 8;
  localparam int         BIT_HOST  = 9;
  localparam int         BIT_SR1RX = 10;
  localparam int         BIT_SR1TX = 11;
  localparam int         BIT_DMA4  = 12;
  localparam int         BIT_DMA5  = 13;
  localparam logic [3:0] SRC_NMI   = 4'he;
  localparam logic [3:0] SRC_RST   = 4'hf;
  // ----------------------------------------
  // slots and priorities
  // ----------------------------------------
  localparam logic [6:0] RESET_SLOT = 7'h00;
  localparam logic [6:0] NMI_SLOT   = 7'h04;
  localparam logic [6:0] SOFT_BASE  = 7'h08;
  localparam logic [6:0] SRC_BASE   = 7'h40;
  localparam logic [6:0] RSVD_SLOT  = 7'h78;
  localparam logic [4:0] RESET_PRIO = 5'h01;
  localparam logic [4:0] NMI_PRIO   = 5'h02;
  localparam logic [4:0] SRC_PRIO   = 5'h03;
  localparam logic [4:0] SOFT_HWMAX = 5'h0d;
  localparam logic [4:0] SOFT_NMI   = 5'h10;
  localparam logic [4:0] SOFT_FIRST = 5'h11;
  localparam logic [4:0] SOFT_RESET = 5'h1f;
  // ----------------------------------------
  // dma source select bits
  // ----------------------------------------
  localparam int DSEL_CH0 = 0;
  localparam int DSEL_CH1 = 1;
  localparam int DSEL_CH2 = 2;
  localparam int DSEL_CH3 = 3;
  // ----------------------------------------
  // register word indices and reset values
  // ----------------------------------------
  localparam logic [2:0]  IDX_FLAGS = 3'h0;
  localparam logic [2:0]  IDX_MASK  = 3'h1;
  localparam logic [2:0]  IDX_DSEL  = 3'h2;
  localparam logic [2:0]  IDX_EVTS  = 3'h3;
  localparam logic [2:0]  IDX_EVTM  = 3'h4;
  localparam logic [2:0]  IDX_STAT  = 3'h5;
  localparam logic [2:0]  IDX_NONE  = 3'h7;
  localparam logic [13:0] FLAGS_RST = 14'h0000;
  localparam logic [13:0] MASK_RST  = 14'h0000;
  localparam logic [3:0]  DSEL_RST  = 4'h0;
  localparam logic [3:0]  EVT_RST   = 4'h0;
  localparam int          EVT_ACK   = 0;
  localparam int          EVT_SOFT  = 1;
  localparam int          EVT_RPIN  = 2;
  localparam int          EVT_NMI   = 3;
endpackage

/* File: div_pin_sync.sv */
// two-flop synchroniser with assertion edge pulse for one pin
`timescale 1ns/1ns
`default_nettype none
module div_pin_sync #(
  parameter bit IDLE = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // pin and pulse
  input  wire logic pinIn,
  output logic      edgePulse
);
  typedef struct packed {
    logic meta;
    logic stab;
    logic prev;
    logic hit;
  } div_sync_s;

  div_sync_s s_q;
  div_sync_s s_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // meta feeds only stab; edge seen on stab/prev
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pinIn;
    s_d.stab = s_q.meta;
    s_d.prev = s_q.stab;
    s_d.hit  = (s_q.prev == IDLE) && (s_q.stab != IDLE);
  end

  // state register
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s_q <= '{meta: IDLE, stab: IDLE, prev: IDLE, hit: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign edgePulse = s_q.hit;
endmodule // div_pin_sync
`default_nettype wire

/* File: div_top.sv */
// interrupt vectoring, prioritisation and register slave
`timescale 1ns/1ns
`default_nettype none
module div_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins, active low
  input  wire logic        hwResetPinN,
  input  wire logic        nmiN,
  input  wire logic [3:0]  extIrqN,
  // on-chip event pulses
  input  wire logic        timer0Irq,
  input  wire logic        timer1Irq,
  input  wire logic        serial0RxIrq,
  input  wire logic        serial0TxIrq,
  input  wire logic        serial1RxIrq,
  input  wire logic        serial1TxIrq,
  input  wire logic        hostPortIrq,
  input  wire logic [5:0]  dmaChIrq,
  // core side
  input  wire logic        softTrapReq,
  input  wire logic [4:0]  softTrapNum,
  input  wire logic        coreAck,
  output logic             vecValid,
  output logic [6:0]       vecAddr,
  output logic [4:0]       vecPrio,
  output logic             softVecValid,
  output logic [6:0]       softVecAddr,
  output logic             irq
);
  typedef struct packed {
    logic [13:0] flags;
    logic [13:0] mask;
    logic [3:0]  dmaSel;
    logic [3:0]  evtSts;
    logic [3:0]  evtMask;
    logic        resetPend;
    logic        nmiPend;
    logic        vecValid;
    logic [6:0]  vecAddr;
    logic [4:0]  vecPrio;
    logic [3:0]  vecSrc;
    logic        softValid;
    logic [6:0]  softAddr;
    logic        irq;
    logic        wrPend;
    logic        rdPend;
    logic [2:0]  regIdx;
    logic        hready;
    logic [31:0] hrdata;
  } div_state_s;

  div_state_s  s_q;
  div_state_s  s_d;
  logic [1:0]  rstSync_q;
  logic        rstN;
  logic [5:0]  pinN;
  logic [5:0]  pinHit;
  logic [13:0] srcEvt;
  logic [13:0] lowMask;

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  // asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync_q <= 2'h0;
    end
    else
    begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];
  assign pinN = {hwResetPinN, nmiN, extIrqN};

  // one synchroniser per pin, falling edge gives a pulse
  for (genvar g = 0; g < 6; g++)
  begin : g_pin
    div_pin_sync #(
      .IDLE (1'b1)
    ) u_sync (
      .clk       (clk),
      .rstN      (rstN),
      .pinIn     (pinN[g]),
      .edgePulse (pinHit[g])
    );
  end

  // ----------------------------------------
  // source to bit routing
  // ----------------------------------------
  // one event vector, same layout as flags and masks
  always_comb
  begin
    srcEvt = 14'h0000;
    srcEvt[2:0] = pinHit[2:0];
    srcEvt[div_pkg::BIT_EXT3] = pinHit[3];
    srcEvt[div_pkg::BIT_TMR0] = timer0Irq;
    srcEvt[div_pkg::BIT_SR0RX] = serial0RxIrq;
    srcEvt[div_pkg::BIT_SR0TX] = serial0TxIrq;
    srcEvt[div_pkg::BIT_DMA0] = s_q.dmaSel[div_pkg::DSEL_CH0]
      & dmaChIrq[0];
    srcEvt[div_pkg::BIT_TMR1] = s_q.dmaSel[div_pkg::DSEL_CH1]
      ? dmaChIrq[1] : timer1Irq;
    srcEvt[div_pkg::BIT_HOST] = hostPortIrq;
    srcEvt[div_pkg::BIT_SR1RX] = s_q.dmaSel[div_pkg::DSEL_CH2]
      ? dmaChIrq[2] : serial1RxIrq;
    srcEvt[div_pkg::BIT_SR1TX] = s_q.dmaSel[div_pkg::DSEL_CH3]
      ? dmaChIrq[3] : serial1TxIrq;
    srcEvt[div_pkg::BIT_DMA4] = dmaChIrq[4];
    srcEvt[div_pkg::BIT_DMA5] = dmaChIrq[5];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic        take;
    logic        wrOk;
    logic [13:0] clr;
    logic [13:0] pend;
    logic [3:0]  evt;
    logic [3:0]  evtClr;
    logic [2:0]  idx;
    take   = 1'b0;
    wrOk   = 1'b0;
    clr    = 14'h0000;
    pend   = 14'h0000;
    evt    = 4'h0;
    evtClr = 4'h0;
    idx    = div_pkg::IDX_NONE;
    s_d    = s_q;

    // address phase decode
    take = hsel && htrans[1] && hready;
    if (haddr[31:5] == 27'h000_0000 && haddr[4:2] <= div_pkg::IDX_STAT)
    begin
      idx = haddr[4:2];
    end
    s_d.wrPend = take && hwrite && (hsize == 3'h2);
    s_d.regIdx = take ? idx : s_q.regIdx;

    // data phase writes; dma select is a plain mapped word
    wrOk = s_q.wrPend;
    if (wrOk && s_q.regIdx == div_pkg::IDX_FLAGS)
    begin
      clr = hwdata[13:0]; // write one to drop a flag
    end
    if (wrOk && s_q.regIdx == div_pkg::IDX_MASK)
    begin
      s_d.mask = hwdata[13:0];
    end
    if (wrOk && s_q.regIdx == div_pkg::IDX_DSEL)
    begin
      s_d.dmaSel = hwdata[3:0];
    end
    if (wrOk && s_q.regIdx == div_pkg::IDX_EVTS)
    begin
      evtClr = hwdata[3:0];
    end
    if (wrOk && s_q.regIdx == div_pkg::IDX_EVTM)
    begin
      s_d.evtMask = hwdata[3:0];
    end

    // reads take one wait state so writes are seen
    s_d.hready = 1'b1;
    s_d.rdPend = take && !hwrite;
    if (take && !hwrite)
    begin
      s_d.hready = 1'b0;
    end
    if (s_q.rdPend)
    begin
      case (s_q.regIdx)
        div_pkg::IDX_FLAGS: s_d.hrdata = {18'h0_0000, s_q.flags};
        div_pkg::IDX_MASK:  s_d.hrdata = {18'h0_0000, s_q.mask};
        div_pkg::IDX_DSEL:  s_d.hrdata = {28'h000_0000, s_q.dmaSel};
        div_pkg::IDX_EVTS:  s_d.hrdata = {28'h000_0000, s_q.evtSts};
        div_pkg::IDX_EVTM:  s_d.hrdata = {28'h000_0000, s_q.evtMask};
        div_pkg::IDX_STAT:  s_d.hrdata = {19'h0_0000, s_q.vecValid,
                                           s_q.vecPrio, s_q.vecAddr};
        default:            s_d.hrdata = 32'h0000_0000;
      endcase
    end

    // acceptance by the core clears the shown source
    if (coreAck && s_q.vecValid)
    begin
      evt[div_pkg::EVT_ACK] = 1'b1;
      if (s_q.vecSrc == div_pkg::SRC_RST)
      begin
        s_d.resetPend = 1'b0;
      end
      else if (s_q.vecSrc == div_pkg::SRC_NMI)
      begin
        s_d.nmiPend = 1'b0;
      end
      else
      begin
        clr[s_q.vecSrc] = 1'b1;
      end
    end

    // set wins over any clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | srcEvt;
    s_d.resetPend = s_d.resetPend | pinHit[5];
    s_d.nmiPend = s_d.nmiPend | pinHit[4];

    // lowest bit wins, then nmi, then reset above all
    pend = s_d.flags & s_d.mask;
    s_d.vecValid = 1'b0;
    s_d.vecSrc = 4'h0;
    s_d.vecAddr = div_pkg::RESET_SLOT;
    s_d.vecPrio = div_pkg::RESET_PRIO;
    for (int i = div_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        s_d.vecValid = 1'b1;
        s_d.vecSrc = 4'(i);
        s_d.vecAddr = div_pkg::SRC_BASE + 7'(4 * i);
        s_d.vecPrio = div_pkg::SRC_PRIO + 5'(i);
      end
    end
    if (s_d.nmiPend)
    begin
      s_d.vecValid = 1'b1;
      s_d.vecSrc = div_pkg::SRC_NMI;
      s_d.vecAddr = div_pkg::NMI_SLOT;
      s_d.vecPrio = div_pkg::NMI_PRIO;
    end
    if (s_d.resetPend)
    begin
      s_d.vecValid = 1'b1;
      s_d.vecSrc = div_pkg::SRC_RST;
      s_d.vecAddr = div_pkg::RESET_SLOT;
      s_d.vecPrio = div_pkg::RESET_PRIO;
    end

    // software traps map a number to a slot, no mask
    s_d.softValid = 1'b0;
    s_d.softAddr = s_q.softAddr;
    if (softTrapReq)
    begin
      s_d.softValid = 1'b1;
      if (softTrapNum <= div_pkg::SOFT_HWMAX)
      begin
        s_d.softAddr = div_pkg::SRC_BASE + {softTrapNum, 2'b00};
      end
      else if (softTrapNum == div_pkg::SOFT_NMI)
      begin
        s_d.softAddr = div_pkg::NMI_SLOT;
      end
      else if (softTrapNum == div_pkg::SOFT_RESET)
      begin
        s_d.softAddr = div_pkg::RESET_SLOT;
      end
      else if (softTrapNum >= div_pkg::SOFT_FIRST)
      begin
        s_d.softAddr = div_pkg::SOFT_BASE
          + {softTrapNum - div_pkg::SOFT_FIRST, 2'b00};
      end
      else
      begin
        s_d.softValid = 1'b0; // numbers 14 and 15 have no slot
      end
    end

    // sticky block events and the level interrupt
    evt[div_pkg::EVT_SOFT] = s_d.softValid;
    evt[div_pkg::EVT_RPIN] = pinHit[5];
    evt[div_pkg::EVT_NMI] = pinHit[4];
    s_d.evtSts = (s_q.evtSts & ~evtClr) | evt;
    s_d.irq = |(s_d.evtSts & s_d.evtMask);
  end

  // state register
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s_q <= '{flags: div_pkg::FLAGS_RST, mask: div_pkg::MASK_RST,
               dmaSel: div_pkg::DSEL_RST, evtSts: div_pkg::EVT_RST,
               evtMask: div_pkg::EVT_RST, hready: 1'b1, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout    = s_q.hready;
  assign hresp        = 1'b0;
  assign hrdata       = s_q.hrdata;
  assign vecValid     = s_q.vecValid;
  assign vecAddr      = s_q.vecAddr;
  assign vecPrio      = s_q.vecPrio;
  assign softVecValid = s_q.softValid;
  assign softVecAddr  = s_q.softAddr;
  assign irq          = s_q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  assign lowMask = (14'h0001 << s_q.vecSrc) - 14'h0001;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  sequence hwShown;
    s_q.vecValid && (s_q.vecSrc < div_pkg::SRC_NMI);
  endsequence

  sequence hwAccepted;
    hwShown ##0 coreAck && !srcEvt[s_q.vecSrc];
  endsequence

  slot_align_a: assert property (
    s_q.vecValid |-> s_q.vecAddr[1:0] == 2'h0
      && s_q.vecAddr < div_pkg::RSVD_SLOT)
    else $error("vector slot misaligned or reserved");

  reset_first_a: assert property (
    s_q.resetPend |-> s_q.vecValid && s_q.vecAddr == 7'h00
      && s_q.vecPrio == 5'h01)
    else $error("reset not presented first");

  nmi_next_a: assert property (
    s_q.nmiPend && !s_q.resetPend |-> s_q.vecAddr == 7'h04
      && s_q.vecPrio == 5'h02)
    else $error("nmi slot or priority wrong");

  hw_slot_a: assert property (
    hwShown |-> s_q.vecAddr == 7'h40 + 7'({s_q.vecSrc, 2'b00})
      && s_q.vecPrio == 5'h03 + 5'(s_q.vecSrc))
    else $error("hardware slot or priority wrong");

  timer0_flag_a: assert property (
    timer0Irq |=> s_q.flags[3])
    else $error("timer 0 flag not set");

  dma0_gate_a: assert property (
    !s_q.dmaSel[0] && !s_q.flags[6] |=> !s_q.flags[6])
    else $error("reserved bit 6 set without dma select");

  timer1_default_a: assert property (
    !s_q.dmaSel[1] && timer1Irq |=> s_q.flags[7])
    else $error("timer 1 not routed to bit 7");

  mask_gate_a: assert property (
    hwShown |-> s_q.mask[s_q.vecSrc] && s_q.flags[s_q.vecSrc])
    else $error("masked source presented");

  prio_order_a: assert property (
    hwShown |-> (s_q.flags & s_q.mask & lowMask) == 14'h0000
      && !s_q.nmiPend && !s_q.resetPend)
    else $error("higher priority source bypassed");

  ack_clear_a: assert property (
    hwAccepted |=> !s_q.flags[$past(s_q.vecSrc)])
    else $error("accepted flag not cleared");

  soft_trap_a: assert property (
    softTrapReq && softTrapNum == 5'h11 |=> s_q.softValid
      && s_q.softAddr == 7'h08)
    else $error("software trap 17 slot wrong");

  rsvd_read_a: assert property (
    $rose(s_q.hready) |-> s_q.hrdata[31:14] == 18'h0_0000)
    else $error("reserved read bits not zero");
endmodule // div_top
`default_nettype wire

/* File: div_far_model.sv */
// core-side partner model: accepts shown vectors after a programmable wait
`timescale 1ns/1ns
`default_nettype none
module div_far_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstN,
  // bench control
  input  wire logic       ackEnable,
  input  wire logic [3:0] ackDelay,
  // vector port
  input  wire logic       vecValid,
  output logic            coreAck
);
  logic [3:0] waitQ;

  // count cycles of a standing vector, then accept it with a one-cycle pulse
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      waitQ   <= 4'h0;
      coreAck <= 1'b0;
    end
    else
    begin
      coreAck <= 1'b0;
      if (coreAck || !vecValid || !ackEnable)
        waitQ <= 4'h0; // never ack twice for one shown vector
      else if (waitQ >= ackDelay)
      begin
        coreAck <= 1'b1;
        waitQ   <= 4'h0;
      end
      else
        waitQ <= waitQ + 4'h1;
    end
  end
endmodule // div_far_model
`default_nettype wire

/* File: div_top_tb.sv */
// self-checking bench for the interrupt vectoring block
`timescale 1ns/1ns
`default_nettype none
module div_top_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwResetPinN, nmiN, timer0Irq, timer1Irq, hostPortIrq;
  logic        serial0RxIrq, serial0TxIrq, serial1RxIrq, serial1TxIrq;
  logic [3:0]  extIrqN, ackDelay;
  logic [5:0]  dmaChIrq;
  logic        softTrapReq, coreAck, vecValid, softVecValid, irq, ackEnable;
  logic [4:0]  softTrapNum, vecPrio;
  logic [6:0]  vecAddr, softVecAddr;
  int          errors, checksDone;
  int          trapNum [7] = '{0, 13, 16, 17, 30, 31, 14};
  int          trapAdr [7] = '{64, 116, 4, 8, 60, 0, 0};

  // ----------------------------------------
  // instances
  // ----------------------------------------
  div_top u_div_top (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hwResetPinN(hwResetPinN),
    .nmiN(nmiN), .extIrqN(extIrqN), .timer0Irq(timer0Irq), .timer1Irq(timer1Irq),
    .serial0RxIrq(serial0RxIrq), .serial0TxIrq(serial0TxIrq), .serial1RxIrq(serial1RxIrq),
    .serial1TxIrq(serial1TxIrq), .hostPortIrq(hostPortIrq), .dmaChIrq(dmaChIrq),
    .softTrapReq(softTrapReq), .softTrapNum(softTrapNum), .coreAck(coreAck),
    .vecValid(vecValid), .vecAddr(vecAddr), .vecPrio(vecPrio), .softVecValid(softVecValid),
    .softVecAddr(softVecAddr), .irq(irq));
  div_far_model u_div_far_model (.clk(clk), .rstN(arst_n), .ackEnable(ackEnable),
    .ackDelay(ackDelay), .vecValid(vecValid), .coreAck(coreAck));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // wait for hready sampled high at a falling edge, taking read data there
  task automatic waitReady(output logic [31:0] rd);
    logic r;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
      if (r === 1'b1)
        return;
    end
    errors++;
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    waitReady(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady(rd);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(a, 1'b1, d, rd);
  endtask

  task automatic rdChk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(a, 1'b0, 32'h0000_0000, rd);
    chk(what, rd, exp);
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // one event on a source bit; dma picks the dma source of switchable bits
  task automatic pulseSrc(input int b, input bit dma);
    @(posedge clk);
    case (b)
      0, 1, 2: extIrqN[b] <= 1'b0;
      3:       timer0Irq <= 1'b1;
      4:       serial0RxIrq <= 1'b1;
      5:       serial0TxIrq <= 1'b1;
      6:       dmaChIrq[0] <= dma;
      7:       if (dma) dmaChIrq[1] <= 1'b1; else timer1Irq <= 1'b1;
      8:       extIrqN[3] <= 1'b0;
      9:       hostPortIrq <= 1'b1;
      10:      if (dma) dmaChIrq[2] <= 1'b1; else serial1RxIrq <= 1'b1;
      11:      if (dma) dmaChIrq[3] <= 1'b1; else serial1TxIrq <= 1'b1;
      12:      dmaChIrq[4] <= 1'b1;
      13:      dmaChIrq[5] <= 1'b1;
      14:      nmiN <= 1'b0;
      default: hwResetPinN <= 1'b0;
    endcase
    @(posedge clk);
    {extIrqN, nmiN, hwResetPinN} <= 6'h3f;
    {timer0Irq, timer1Irq, serial0RxIrq, serial0TxIrq} <= 4'h0;
    {serial1RxIrq, serial1TxIrq, hostPortIrq, dmaChIrq} <= 9'h000;
  endtask

  // let the partner accept until nothing is shown
  task automatic ackAll(input logic [3:0] d);
    ackDelay <= d;
    ackEnable <= 1'b1;
    for (int n = 0; n < 60 && vecValid !== 1'b0; n++)
      @(negedge clk);
    chk("vector drained", vecValid, 32'h0);
    @(posedge clk);
    ackEnable <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testRegs();
    // idle status word carries the reset priority in its priority field
    for (int i = 0; i < 6; i++)
      rdChk("reset value", 32'(i * 4), (i == 5) ? 32'h0000_0080 : 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_ffff);
    rdChk("mask reserved", 32'h0000_0004, 32'h0000_3fff);
    chk("okay response", hresp, 32'h0);
    hsize <= 3'h0;
    wr(32'h0000_0004, 32'h0000_0000);
    hsize <= 3'h2;
    rdChk("byte write dropped", 32'h0000_0004, 32'h0000_3fff);
    wr(32'h0000_001c, 32'h0000_0005);
    rdChk("unmapped", 32'h0000_001c, 32'h0000_0000);
  endtask

  task automatic testMap();
    logic [31:0] exp;
    for (int s = 0; s < 2; s++)
    begin
      wr(32'h0000_0008, s ? 32'h0000_000f : 32'h0000_0000);
      rdChk("dma select", 32'h0000_0008, s ? 32'h0000_000f : 32'h0000_0000);
      for (int b = 0; b < 14; b++)
      begin
        wr(32'h0000_0000, 32'h0000_3fff);
        if (b == 6 || b == 7 || b == 10 || b == 11)
        begin
          pulseSrc(b, !s);
          settle();
          rdChk("unselected source", 32'h0000_0000, 32'h0000_0000);
        end
        exp = (b == 6 && s == 0) ? 32'h0000_0000 : 32'h0000_0001 << b;
        pulseSrc(b, s);
        settle();
        rdChk("flag bit", 32'h0000_0000, exp);
        if (exp != 0)
        begin
          chk("slot", vecAddr, 32'(64 + 4 * b));
          chk("priority", vecPrio, 32'(b + 3));
        end
      end
    end
    wr(32'h0000_0000, 32'h0000_3fff);
  endtask

  task automatic testPrio();
    pulseSrc(13, 1'b0);
    settle();
    chk("lowest slot", vecAddr, 32'd116);
    chk("lowest prio", vecPrio, 32'd16);
    pulseSrc(3, 1'b0);
    settle();
    chk("winner slot", vecAddr, 32'd76);
    rdChk("status word", 32'h0000_0014, 32'h0000_134c);
    ackDelay <= 4'h3;
    ackEnable <= 1'b1;
    for (int n = 0; n < 40 && vecAddr === 7'd76; n++)
      @(negedge clk);
    chk("next winner", vecAddr, 32'd116);
    ackAll(4'h3);
    rdChk("flags after accept", 32'h0000_0000, 32'h0000_0000);
  endtask

  task automatic testPins();
    wr(32'h0000_0004, 32'h0000_0000);
    wr(32'h0000_000c, 32'h0000_000f);
    pulseSrc(3, 1'b0);
    settle();
    chk("masked off", vecValid, 32'h0);
    rdChk("flag while masked", 32'h0000_0000, 32'h0000_0008);
    wr(32'h0000_0004, 32'h0000_0008);
    settle();
    chk("unmasked", vecAddr, 32'd76);
    wr(32'h0000_0004, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_3fff);
    pulseSrc(14, 1'b0);
    settle();
    chk("nmi slot", vecAddr, 32'd4);
    chk("nmi prio", vecPrio, 32'd2);
    rdChk("nmi event", 32'h0000_000c, 32'h0000_0008);
    wr(32'h0000_0010, 32'h0000_0008);
    settle();
    chk("irq raised", irq, 32'h1);
    wr(32'h0000_000c, 32'h0000_0008);
    settle();
    chk("irq cleared", irq, 32'h0);
    ackAll(4'h0);
    pulseSrc(15, 1'b0);
    settle();
    chk("reset slot", vecAddr, 32'd0);
    chk("reset prio", vecPrio, 32'd1);
    ackAll(4'h5);
    rdChk("accept and pin events", 32'h0000_000c, 32'h0000_0005);
    wr(32'h0000_0010, 32'h0000_0000);
  endtask

  task automatic testSoft();
    wr(32'h0000_000c, 32'h0000_000f);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      softTrapReq <= 1'b1;
      softTrapNum <= 5'(trapNum[i]);
      @(posedge clk);
      softTrapReq <= 1'b0;
      @(negedge clk);
      chk("trap pulse", softVecValid, (i < 6) ? 32'h1 : 32'h0);
      if (i < 6)
        chk("trap slot", softVecAddr, 32'(trapAdr[i]));
    end
    rdChk("trap event", 32'h0000_000c, 32'h0000_0002);
  endtask

  // reset in mid-run drops the shown vector and clears the registers
  task automatic testReset();
    wr(32'h0000_0004, 32'h0000_0008);
    pulseSrc(3, 1'b0);
    settle();
    chk("before reset", vecValid, 32'h1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("vector after reset", vecValid, 32'h0);
    rdChk("flags after reset", 32'h0000_0000, 32'h0000_0000);
    rdChk("mask after reset", 32'h0000_0004, 32'h0000_0000);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    {arst_n, hsel, hwrite, haddr, hwdata, htrans, softTrapReq, softTrapNum} = '0;
    {extIrqN, nmiN, hwResetPinN, ackEnable, ackDelay} = 11'h7e0;
    {timer0Irq, timer1Irq, serial0RxIrq, serial0TxIrq, serial1RxIrq} = 5'h00;
    {serial1TxIrq, hostPortIrq, dmaChIrq} = 8'h00;
    {errors, checksDone} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    testRegs();
    testMap();
    testPrio();
    testPins();
    testSoft();
    testReset();
    tally_and_finish();
  end
endmodule // div_top_tb
`default_nettype wire
